// file: core/ctap_core.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Each 32-bit register splits into two 16-bit halves, low half at the even lower address.
// - In PWM mode a write to the period or compare slot also lands in its shadow slot.
// - In PWM mode a write to a shadow slot selects shadowed updating.
// - Counter, phase and the four capture slots decode at 0h, 4h, 8h, Ch, 10h and 14h.
// - Controls decode at 28h and 2Ah, interrupt registers at 2Ch to 32h, revision at 5Ch.
// - The time-stamp counter is 32 bits, read-write, resets to zero and times every capture.
// - The phase value is copied into the counter on a sync input event or a software sync.
// - A capture event loads the counter into the slot the sequencer points at, then the sequencer advances.
// - Software may write each capture slot directly and the value is stored.
// - In PWM mode the first slot is the active period.
// - In PWM mode the second slot is the active compare that sets the output edge.
// - The third slot holds time-stamps in capture mode and is the period shadow in PWM mode.
// - The fourth slot holds time-stamps in capture mode and is the compare shadow in PWM mode.
// - Slots load on events only while capture load enable is set.
// - Active-high polarity makes compare the high time, active-low makes it the low time.
module ctap_core
#(
  parameter logic [31:0] REVISION = ctap_pkg::REVISION_DEFAULT
)
(
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire ctap_pkg::ctap_bus_req_t bus_req,
  input  wire logic                   capture_input,
  input  wire logic                   sync_input_event,
  output var  logic [15:0]            read_data,
  output var  logic                   irq,
  output var  logic                   pwm_output
);
  import ctap_pkg::*;

  ctap_core_state_t st;
  ctap_core_state_t next_st;

  logic [SLOTS-1:0] slot_hit;
  logic [SLOTS-1:0] pol_vec;
  logic [SLOTS-1:0] rst_vec;
  logic             rise;
  logic             fall;
  logic             pwm_mode;
  logic             half;
  logic [6:0]       word_addr;
  logic             prd_match;
  logic             evt;
  logic             sw_sync;
  logic [31:0]      word;

  // ----------------------------------------
  // Input edges
  // ----------------------------------------
  ctap_edge u_edge
  (
    .clock   (clock),
    .reset_n (reset_n),
    .sample  (capture_input),
    .rise    (rise),
    .fall    (fall)
  );

  // ----------------------------------------
  // Per-slot decode and event fields
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++)
    begin : g_slot
      assign slot_hit[g] = bus_req.wr
        && (bus_req.addr[6:2] == OFF_SLOT1[6:2] + 5'(g));
      assign pol_vec[g] = st.ctl1[CTL1_POL_BASE + CTL1_STRIDE * g];
      assign rst_vec[g] = st.ctl1[CTL1_RST_BASE + CTL1_STRIDE * g];
    end
  endgenerate

  function automatic logic [31:0] put_half(logic [31:0] v, logic hi, logic [15:0] d);
    put_half = hi ? {d, v[15:0]} : {v[31:16], d};
  endfunction

  assign pwm_mode  = st.ctl2[BIT_PWM_MODE];
  assign half      = bus_req.addr[1];
  assign word_addr = bus_req.addr & WORD_MASK;
  assign prd_match = pwm_mode && (st.counter == st.slot[0]);
  assign evt       = !pwm_mode && (pol_vec[st.seq] ? fall : rise);
  assign sw_sync   = bus_req.wr && word_addr == (OFF_CTL2 & WORD_MASK) && half
                     && bus_req.wdata[BIT_SW_SYNC];

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    case (word_addr)
      OFF_COUNTER:               word = st.counter;
      OFF_PHASE:                 word = st.phase;
      OFF_SLOT1:                 word = st.slot[0];
      OFF_SLOT2:                 word = st.slot[1];
      OFF_SLOT3:                 word = st.slot[2];
      OFF_SLOT4:                 word = st.slot[3];
      OFF_CTL1:                  word = {st.ctl2, st.ctl1};
      OFF_INT_EN:                word = {st.flags, st.int_en};
      OFF_REVISION:              word = REVISION;
      default:                   word = '0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st       = st;
    next_st.rdata = '0;
    if (bus_req.rd)
      next_st.rdata = half ? word[31:16] : word[15:0];

    // Clear first so a same-cycle event wins
    if (bus_req.wr && word_addr == (OFF_INT_CLEAR & WORD_MASK) && !half)
      next_st.flags = st.flags & ~bus_req.wdata;
    if (bus_req.wr && word_addr == (OFF_INT_FORCE & WORD_MASK) && half)
      next_st.flags = next_st.flags | (bus_req.wdata & FLG_MASK);

    // Time base
    if (st.ctl2[BIT_RUN])
    begin
      if (prd_match)
      begin
        next_st.counter        = '0;
        next_st.flags[FLG_PRD] = 1'b1;
      end
      else
      begin
        next_st.counter = st.counter + 32'h0000_0001;
      end
      if (!pwm_mode && &st.counter)
        next_st.flags[FLG_OVF] = 1'b1;
    end
    if (pwm_mode && st.counter == st.slot[1])
      next_st.flags[FLG_CMP] = 1'b1;

    // Shadow transfer only at period, so a cycle is never cut short
    if (prd_match && st.shadowed)
    begin
      next_st.slot[0] = st.slot[2];
      next_st.slot[1] = st.slot[3];
    end

    // Capture sequencer
    if (evt)
    begin
      if (st.ctl1[BIT_LOAD_EN])
        next_st.slot[st.seq] = st.counter;
      next_st.flags[FLG_EVT_BASE + 32'(st.seq)] = 1'b1;
      if (rst_vec[st.seq])
        next_st.counter = '0;
      if (st.seq == st.ctl2[WRAP_LO +: 2])
        next_st.seq = '0;
      else
        next_st.seq = st.seq + 2'h1;
    end

    // Phase load
    if ((sync_input_event && st.ctl2[BIT_SYNC_EN]) || sw_sync)
      next_st.counter = st.phase;

    // Software writes take priority over hardware updates
    if (bus_req.wr && word_addr == OFF_COUNTER)
      next_st.counter = put_half(st.counter, half, bus_req.wdata);
    if (bus_req.wr && word_addr == OFF_PHASE)
      next_st.phase = put_half(st.phase, half, bus_req.wdata);
    for (int k = 0; k < SLOTS; k++)
    begin
      if (slot_hit[k])
      begin
        next_st.slot[k] = put_half(st.slot[k], half, bus_req.wdata);
        if (pwm_mode && k < 2)
        begin
          next_st.slot[k ^ 2] = put_half(st.slot[k], half, bus_req.wdata);
          next_st.shadowed    = 1'b0;
        end
        else if (pwm_mode)
        begin
          next_st.shadowed = 1'b1;
        end
      end
    end
    if (bus_req.wr && word_addr == (OFF_CTL1 & WORD_MASK))
    begin
      if (half)
        next_st.ctl2 = bus_req.wdata & CTL2_WMASK;
      else
        next_st.ctl1 = bus_req.wdata;
    end
    if (bus_req.wr && word_addr == (OFF_INT_EN & WORD_MASK) && !half)
      next_st.int_en = bus_req.wdata & FLG_MASK;

    next_st.irq = |(next_st.flags & next_st.int_en);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st      <= '0;
      st.ctl1 <= CTL1_RESET;
      st.ctl2 <= CTL2_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // PWM output
  // ----------------------------------------
  ctap_pwm u_pwm
  (
    .clock       (clock),
    .reset_n     (reset_n),
    .enable      (pwm_mode),
    .active_high (!st.ctl2[BIT_OUT_POL]),
    .counter     (st.counter),
    .compare     (st.slot[1]),
    .level       (pwm_output)
  );

  assign read_data = st.rdata;
  assign irq       = st.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_shadow_copy_one: assert property (@(posedge clock) disable iff (!reset_n)
    pwm_mode && slot_hit[0] && !half |=> st.slot[2][15:0] == st.slot[0][15:0])
    else $error("period write not copied to shadow");

  a_shadow_select: assert property (@(posedge clock) disable iff (!reset_n)
    pwm_mode && (slot_hit[2] || slot_hit[3]) |=> st.shadowed)
    else $error("shadow write did not select shadow mode");

  a_phase_load: assert property (@(posedge clock) disable iff (!reset_n)
    sw_sync && !(bus_req.wr && word_addr == OFF_COUNTER)
    |=> st.counter == $past(st.phase))
    else $error("phase not loaded on software sync");

  a_capture_load: assert property (@(posedge clock) disable iff (!reset_n)
    evt && st.ctl1[BIT_LOAD_EN] && st.seq == 2'h0 && !slot_hit[0]
    |=> st.slot[0] == $past(st.counter))
    else $error("capture slot not loaded");

  a_load_gated: assert property (@(posedge clock) disable iff (!reset_n)
    evt && !st.ctl1[BIT_LOAD_EN] && !bus_req.wr |=> $stable(st.slot))
    else $error("slot changed with load disabled");

  a_slot_write: assert property (@(posedge clock) disable iff (!reset_n)
    slot_hit[1] && half |=> st.slot[1][31:16] == $past(bus_req.wdata))
    else $error("slot write not stored");

  a_period_transfer: assert property (@(posedge clock) disable iff (!reset_n)
    prd_match && st.shadowed && !(|slot_hit) |=> st.slot[0] == $past(st.slot[2]))
    else $error("shadow period not transferred");

  a_read_counter: assert property (@(posedge clock) disable iff (!reset_n)
    bus_req.rd && bus_req.addr == OFF_COUNTER
    |=> read_data == $past(st.counter[15:0]) ##1 read_data == 16'h0000)
    else $error("counter read data wrong");

  a_counter_reset: assert property (@(posedge clock)
    $rose(reset_n) |-> st.counter == 32'h0000_0000)
    else $error("counter not zero after reset");

  // ----------------------------------------
  // Shadow, counter, sequencer, flag and output checks
  // ----------------------------------------
  a_shadow_copy_two: assert property (@(posedge clock) disable iff (!reset_n)
    pwm_mode && slot_hit[1] && half |=> st.slot[3][31:16] == st.slot[1][31:16])
    else $error("compare write not copied to shadow");

  a_active_write: assert property (@(posedge clock) disable iff (!reset_n)
    pwm_mode && (slot_hit[0] || slot_hit[1]) |=> !st.shadowed)
    else $error("active write did not select immediate mode");

  a_compare_transfer: assert property (@(posedge clock) disable iff (!reset_n)
    prd_match && st.shadowed && !(|slot_hit) |=> st.slot[1] == $past(st.slot[3]))
    else $error("shadow compare not transferred");

  // Captures are refused in PWM mode, so only writes or transfers move slots
  a_pwm_no_capture: assert property (@(posedge clock) disable iff (!reset_n)
    pwm_mode && !prd_match && !bus_req.wr |=> $stable(st.slot))
    else $error("slot changed in pwm mode without write");

  a_period_wrap: assert property (@(posedge clock) disable iff (!reset_n)
    st.ctl2[BIT_RUN] && prd_match && !bus_req.wr && !sync_input_event
    |=> st.counter == 32'h0000_0000)
    else $error("counter did not wrap at period");

  // Conservative: any event, sync pulse or write may move the counter
  a_counter_count: assert property (@(posedge clock) disable iff (!reset_n)
    st.ctl2[BIT_RUN] && !prd_match && !evt && !sync_input_event && !bus_req.wr
    |=> st.counter == $past(st.counter) + 32'h0000_0001)
    else $error("counter did not advance");

  a_overflow_flag: assert property (@(posedge clock) disable iff (!reset_n)
    st.ctl2[BIT_RUN] && !pwm_mode && &st.counter |=> st.flags[FLG_OVF])
    else $error("overflow flag not set");

  a_sync_input_load: assert property (@(posedge clock) disable iff (!reset_n)
    sync_input_event && st.ctl2[BIT_SYNC_EN] && !bus_req.wr
    |=> st.counter == $past(st.phase))
    else $error("phase not loaded on sync input");

  a_counter_hold: assert property (@(posedge clock) disable iff (!reset_n)
    !st.ctl2[BIT_RUN] && !st.ctl2[BIT_SYNC_EN] && !evt && !bus_req.wr
    |=> $stable(st.counter))
    else $error("stopped counter moved");

  a_capture_reset: assert property (@(posedge clock) disable iff (!reset_n)
    evt && rst_vec[st.seq] && !bus_req.wr && !(sync_input_event && st.ctl2[BIT_SYNC_EN])
    |=> st.counter == 32'h0000_0000)
    else $error("counter not reset after event");

  a_seq_wrap: assert property (@(posedge clock) disable iff (!reset_n)
    evt && st.seq == st.ctl2[WRAP_LO +: 2] |=> st.seq == 2'h0)
    else $error("sequencer did not wrap");

  a_pwm_off: assert property (@(posedge clock) disable iff (!reset_n)
    !pwm_mode |=> !pwm_output)
    else $error("pwm output high outside pwm mode");

  a_read_idle: assert property (@(posedge clock) disable iff (!reset_n)
    !bus_req.rd |=> read_data == 16'h0000)
    else $error("read data not zero when idle");

  a_flag_clear: assert property (@(posedge clock) disable iff (!reset_n)
    bus_req.wr && word_addr == (OFF_INT_CLEAR & WORD_MASK) && !half && !evt
    && !st.ctl2[BIT_RUN] && !pwm_mode |=> (st.flags & $past(bus_req.wdata)) == 16'h0000)
    else $error("flag clear lost");

  // Level output, so it must track flags and enable on every cycle
  a_irq_level: assert property (@(posedge clock) disable iff (!reset_n)
    irq == |(st.flags & st.int_en))
    else $error("irq does not match flags and enable");
endmodule // ctap_core
`default_nettype wire

// file: common/ctap_pkg.sv
`default_nettype none
package ctap_pkg;
  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int SLOTS  = 4;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [6:0] OFF_COUNTER   = 7'h00;
  localparam logic [6:0] OFF_PHASE     = 7'h04;
  localparam logic [6:0] OFF_SLOT1     = 7'h08;
  localparam logic [6:0] OFF_SLOT2     = 7'h0C;
  localparam logic [6:0] OFF_SLOT3     = 7'h10;
  localparam logic [6:0] OFF_SLOT4     = 7'h14;
  localparam logic [6:0] OFF_CTL1      = 7'h28;
  localparam logic [6:0] OFF_CTL2      = 7'h2A;
  localparam logic [6:0] OFF_INT_EN    = 7'h2C;
  localparam logic [6:0] OFF_INT_FLAGS = 7'h2E;
  localparam logic [6:0] OFF_INT_CLEAR = 7'h30;
  localparam logic [6:0] OFF_INT_FORCE = 7'h32;
  localparam logic [6:0] OFF_REVISION  = 7'h5C;
  localparam logic [6:0] WORD_MASK     = 7'h7C;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTL1_POL_BASE = 0;
  localparam int CTL1_RST_BASE = 1;
  localparam int CTL1_STRIDE   = 2;
  localparam int BIT_LOAD_EN   = 8;
  localparam int BIT_RUN       = 4;
  localparam int BIT_SYNC_EN   = 5;
  localparam int BIT_SW_SYNC   = 8;
  localparam int BIT_PWM_MODE  = 9;
  localparam int BIT_OUT_POL   = 10;
  localparam int WRAP_LO       = 1;
  localparam int FLG_EVT_BASE  = 1;
  localparam int FLG_OVF       = 5;
  localparam int FLG_PRD       = 6;
  localparam int FLG_CMP       = 7;
  localparam logic [15:0] CTL1_RESET = 16'h0000;
  localparam logic [15:0] CTL2_RESET = 16'h0006;
  localparam logic [15:0] CTL2_WMASK = 16'h0636;
  localparam logic [15:0] FLG_MASK   = 16'h00FE;
  // Arbitrary revision value
  localparam logic [31:0] REVISION_DEFAULT = 32'h0000_0A5A;

  // ----------------------------------------
  // Carriers and state
  // ----------------------------------------
  typedef struct packed {
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ctap_bus_req_t;

  typedef struct packed {
    logic [31:0]            counter;
    logic [31:0]            phase;
    logic [3:0][31:0]       slot;
    logic [15:0]            ctl1;
    logic [15:0]            ctl2;
    logic [15:0]            int_en;
    logic [15:0]            flags;
    logic [15:0]            rdata;
    logic [1:0]             seq;
    logic                   shadowed;
    logic                   irq;
  } ctap_core_state_t;

  typedef struct packed {
    logic prev;
    logic rise;
    logic fall;
  } ctap_edge_state_t;

  typedef struct packed {
    logic level;
  } ctap_pwm_state_t;
endpackage
`default_nettype wire

// file: core/ctap_edge.sv
`timescale 1ns/1ps
`default_nettype none
module ctap_edge
(
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic sample,
  output var  logic rise,
  output var  logic fall
);
  import ctap_pkg::*;

  ctap_edge_state_t st;
  ctap_edge_state_t next_st;

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  always_comb
  begin
    next_st      = st;
    next_st.prev = sample;
    next_st.rise = sample && !st.prev;
    next_st.fall = !sample && st.prev;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign rise = st.rise;
  assign fall = st.fall;
endmodule // ctap_edge
`default_nettype wire

// file: core/ctap_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module ctap_pwm
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        enable,
  input  wire logic        active_high,
  input  wire logic [31:0] counter,
  input  wire logic [31:0] compare,
  output var  logic        level
);
  import ctap_pkg::*;

  ctap_pwm_state_t st;
  ctap_pwm_state_t next_st;

  // ----------------------------------------
  // Output level
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    // Compare gives the active time for either polarity
    next_st.level = enable && ((counter < compare) == active_high);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign level = st.level;

  a_pwm_low_time: assert property (@(posedge clock) disable iff (!reset_n)
    enable && !active_high && counter < compare |=> !level)
    else $error("pwm not low during compare time");
endmodule // ctap_pwm
`default_nettype wire

// file: test/ctap_host.sv
`timescale 1ns/1ps
`default_nettype none
module ctap_host
(
  input  wire logic                    clock,
  output var  ctap_pkg::ctap_bus_req_t bus_req,
  input  wire logic [15:0]             read_data
);
  import ctap_pkg::*;
  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  initial
  begin
    bus_req = '0;
  end

  // Only mapped offsets are ever written
  task automatic write16(input logic [6:0] addr, input logic [15:0] data);
    @(posedge clock);
    bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic read16(input logic [6:0] addr, output logic [15:0] data);
    @(posedge clock);
    bus_req <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    @(negedge clock);
    data = read_data;
  endtask
endmodule // ctap_host
`default_nettype wire

// file: test/ctap_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ctap_core_tb;
  import ctap_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int CEILING = 4000;
  logic          clock;
  logic          reset_n;
  logic          capture_input;
  logic          sync_input_event;
  ctap_bus_req_t bus_req;
  logic [15:0]   read_data;
  logic          irq;
  logic          pwm_output;
  logic [15:0]   half;
  logic [31:0]   word;
  int            err_total;
  int            tests_run;
  int            cycles;
  int            highs;

  ctap_core ctap_core_inst
  (
    .clock            (clock),
    .reset_n          (reset_n),
    .bus_req          (bus_req),
    .capture_input    (capture_input),
    .sync_input_event (sync_input_event),
    .read_data        (read_data),
    .irq              (irq),
    .pwm_output       (pwm_output)
  );

  ctap_host ctap_host_inst
  (
    .clock     (clock),
    .bus_req   (bus_req),
    .read_data (read_data)
  );

  initial
  begin
    clock = 1'b0;
  end
  always #5 clock = ~clock;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr16(input logic [6:0] addr, input logic [15:0] data);
    ctap_host_inst.write16(addr, data);
  endtask

  // Low half first, at the even address
  task automatic wr32(input logic [6:0] addr, input logic [31:0] data);
    wr16(addr, data[15:0]);
    wr16(addr + 7'h02, data[31:16]);
  endtask

  task automatic expect16(input logic [6:0] addr, input logic [15:0] exp);
    ctap_host_inst.read16(addr, half);
    check({16'h0000, half}, {16'h0000, exp});
  endtask

  task automatic expect32(input logic [6:0] addr, input logic [31:0] exp);
    ctap_host_inst.read16(addr, half);
    word[15:0] = half;
    ctap_host_inst.read16(addr + 7'h02, half);
    word[31:16] = half;
    check(word, exp);
  endtask

  task automatic settle;
    repeat (2) @(negedge clock);
  endtask

  // Edge detector needs a cycle of history, slot loads two later
  task automatic pin(input logic v);
    @(posedge clock);
    capture_input <= v;
    repeat (4) @(posedge clock);
  endtask

  // Any 100 cycles hold whole periods of 10 or 20
  task automatic count_high;
    settle();
    highs = 0;
    repeat (100)
    begin
      @(negedge clock);
      if (pwm_output === 1'b1)
        highs++;
    end
  endtask

  function automatic logic [31:0] pat(input int i);
    return 32'h1357_9BDF + 32'(i) * 32'h0101_0101;
  endfunction

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == CEILING)
    begin
      err_total++;
      test_done();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    reset_n = 1'b0;
    capture_input = 1'b0;
    sync_input_event = 1'b0;
    err_total = 0;
    tests_run = 0;
    cycles = 0;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    expect32(OFF_COUNTER, 32'h0000_0000);
    expect32(OFF_SLOT3, 32'h0000_0000);
    expect16(OFF_CTL2, 16'h0006);
    expect32(OFF_REVISION, REVISION_DEFAULT);
    expect16(7'h18, 16'h0000);
    check({31'h0, pwm_output}, 32'h0);
    $display("test reset done");

    for (int i = 0; i < 6; i++) wr32(7'(4 * i), pat(i));
    for (int i = 0; i < 6; i++) expect32(7'(4 * i), pat(i));
    $display("test map done");

    wr32(OFF_PHASE, 32'h0000_1234);
    wr16(OFF_CTL2, 16'h0106);
    expect32(OFF_COUNTER, 32'h0000_1234);
    wr32(OFF_PHASE, 32'h00AB_0100);
    wr16(OFF_CTL2, 16'h0026);
    @(posedge clock);
    sync_input_event <= 1'b1;
    @(posedge clock);
    sync_input_event <= 1'b0;
    expect32(OFF_COUNTER, 32'h00AB_0100);
    $display("test sync done");

    wr16(OFF_CTL1, 16'h0100);
    pin(1'b1);
    expect32(OFF_SLOT1, 32'h00AB_0100);
    expect16(OFF_INT_FLAGS, 16'h0002);
    check({31'h0, irq}, 32'h0);
    wr16(OFF_INT_EN, 16'h0002);
    settle();
    check({31'h0, irq}, 32'h1);
    wr16(OFF_INT_CLEAR, 16'h0002);
    settle();
    check({31'h0, irq}, 32'h0);
    wr16(OFF_INT_FORCE, 16'h0002);
    settle();
    check({31'h0, irq}, 32'h1);
    wr16(OFF_INT_CLEAR, 16'h0006);
    wr16(OFF_CTL1, 16'h0000);
    pin(1'b0);
    pin(1'b1);
    expect32(OFF_SLOT2, pat(3));
    $display("test capture done");

    wr16(OFF_CTL2, 16'h0206);
    wr32(OFF_SLOT1, 32'h0000_0009);
    wr32(OFF_SLOT2, 32'h0000_0004);
    expect32(OFF_SLOT3, 32'h0000_0009);
    expect32(OFF_SLOT4, 32'h0000_0004);
    wr32(OFF_COUNTER, 32'h0000_0000);
    wr16(OFF_CTL2, 16'h0216);
    count_high();
    check(32'(highs), 32'h0000_0028);
    wr16(OFF_CTL2, 16'h0616);
    count_high();
    check(32'(highs), 32'h0000_003C);
    $display("test pwm done");

    // Counter parked at zero so no period match can move the shadow
    wr16(OFF_CTL2, 16'h0206);
    wr16(OFF_COUNTER, 16'h0000);
    wr16(OFF_SLOT3, 16'h0013);
    expect32(OFF_SLOT1, 32'h0000_0009);
    wr16(OFF_CTL2, 16'h0216);
    repeat (40) @(posedge clock);
    expect32(OFF_SLOT1, 32'h0000_0013);
    count_high();
    check(32'(highs), 32'h0000_0014);
    $display("test shadow done");

    // Falling edges 10 cycles apart, counter reset after each, wrap at slot one
    wr16(OFF_CTL2, 16'h0010);
    wr16(OFF_CTL1, 16'h01FF);
    pin(1'b0);
    pin(1'b1);
    pin(1'b0);
    pin(1'b1);
    pin(1'b0);
    expect32(OFF_SLOT4, 32'h0000_0009);
    expect32(OFF_SLOT1, 32'h0000_0009);
    expect16(OFF_INT_FLAGS, 16'h00DE);
    check({31'h0, irq}, 32'h1);
    wr16(OFF_INT_CLEAR, 16'h00FE);
    wr32(OFF_COUNTER, 32'hFFFF_FFF0);
    repeat (20) @(posedge clock);
    expect16(OFF_INT_FLAGS, 16'h0020);
    $display("test events done");
    test_done();
  end
endmodule // ctap_core_tb
`default_nettype wire
